// File: design/pwm_fault_params.svh
// constants for the pwm fault, delay and fraction control block
// assumes byte-wide registers on a plain strobe port
`ifndef PWM_FAULT_PARAMS_SVH
`define PWM_FAULT_PARAMS_SVH
`define ADDR_INPUT_B_FAULT_MODE 8'h11
`define ADDR_FAULT_OVERRIDE_CTRL 8'h12
`define ADDR_DELAY_CTRL 8'h14
`define ADDR_DELAY_COUNT 8'h15
`define ADDR_FRACTION_CTRL 8'h18
`define ADDR_FRACTION_VALUE 8'h19
`define ADDR_DEBUG_HALT_CTRL 8'h1e
`define ADDR_EVENT_B_CTRL 8'h09
`define ADDR_FAULT_STATUS 8'h1f
`define REG_RESET 8'h00
`define MODE_LSB 0
`define MODE_MSB 3
`define OVR_EN_LSB 4
`define OVR_EN_MSB 7
`define OVR_LVL_LSB 0
`define OVR_LVL_MSB 3
`define DLY_SEL_LSB 0
`define DLY_SEL_MSB 1
`define DLY_TRIG_LSB 2
`define DLY_TRIG_MSB 3
`define DLY_DIV_LSB 4
`define DLY_DIV_MSB 5
`define RAMP_LSB 0
`define RAMP_MSB 1
`define FRAC_LSB 0
`define FRAC_MSB 3
`define BIT_DBG_RUN 0
`define BIT_HALT_FAULT 2
`define BIT_TRIG_EN 0
`define BIT_EDGE_SEL 4
`define BIT_SW_RELEASE 0
`endif

// File: design/pwm_fault_pkg.sv
// types for the pwm fault, delay and fraction control block
// assumes pwm_fault_params.svh holds all numeric constants
package pwm_fault_pkg;
  typedef enum logic [10:0] {
    mode_none = 11'h001,
    mode_jump_opposite_and_hold = 11'h002,
    mode_run_opposite_and_hold = 11'h004,
    mode_run_opposite_during_fault = 11'h008,
    mode_stop_all_keep_period = 11'h010,
    mode_deadband_during_fault = 11'h020,
    mode_stop_all_next_and_hold = 11'h040,
    mode_stop_all_until_software = 11'h080,
    mode_edge_stop_next_cycle = 11'h100,
    mode_edge_stop_keep_period = 11'h200,
    mode_level_stop_keep_period = 11'h400
  } reaction_e;
  typedef enum logic [1:0] {
    dly_idle = 2'b01,
    dly_count = 2'b10
  } delay_state_e;
endpackage

// File: design/pwm_fault_delay_fraction_ctrl.sv
// fault reaction, fault override, delay unit and fractional accumulator
// of a 12-bit pwm timer core; counter and compare logic sit outside and
// report cycle phase strobes; event and halt inputs are asynchronous.
// Function
// - mode 0x0: input B trigger leaves outputs untouched
// - mode 0x1: stop output, jump to opposite compare cycle, hold
// - mode 0x2: stop output, finish opposite compare cycle, hold
// - mode 0x3: stop output, run opposite cycle while fault active
// - mode 0x4: stop all outputs, counter keeps running
// - mode 0x5: stop all outputs, run dead-time while fault active
// - mode 0x6: stop all outputs, go to next compare cycle, hold
// - mode 0x7: stop all outputs until software releases them
// - mode 0x8: stop output on edge, jump to next compare cycle
// - mode 0x9: stop output on edge, period kept
// - mode 0xA: stop output while input at active level, period kept
// - override-enable bits 7:4 choose fault default per output
// - during fault an enabled stopped output takes its default level bit
// - delay divider codes 0..3 divide timebase by 1,2,4,8
// - delay start: compare A rise, A fall, B rise, cycle end
// - delay function: off, input blanking, output event, reserved
// - 8-bit delay length counted in prescaled timer cycles
// - ramp select picks which on-time or dead-time gets fraction
// - fraction added to 4-bit accumulator each cycle end while timer runs
// - fraction value double-buffered, loaded on update condition
// - halt-fault option raises fault and both trigger flags on halt
// - debug-run 0 halts timer and ignores events during break
// - trigger-enable bit gates the event as input B trigger
// - edge-select bit picks falling/low or rising/high activity
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "pwm_fault_params.svh"
module pwm_fault_delay_fraction_ctrl
  import pwm_fault_pkg::*;
#(
  parameter int unsigned OUTPUTS = 4,
  parameter int unsigned DELAY_BITS = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // timer core phase strobes, same clock
  input wire logic compare_a_rise,
  input wire logic compare_a_fall,
  input wire logic compare_b_rise,
  input wire logic compare_b_fall_cycle_end,
  input wire logic update_strobe,
  input wire logic [OUTPUTS-1:0] waveform_raw,
  // asynchronous inputs
  input wire logic event_b_in,
  input wire logic cpu_halted,
  // sequencer requests towards the timer core
  output logic jump_opposite,
  output logic jump_next,
  output logic hold_cycle,
  output logic run_deadband,
  output logic timer_run,
  output logic trigger_a_flag_set,
  output logic trigger_b_flag_set,
  // delay unit results
  output logic input_blanking,
  output logic delayed_event,
  // fractional adjustment
  output logic [1:0] fraction_ramp_select,
  output logic fraction_step,
  // pins
  output logic [OUTPUTS-1:0] waveform_pin
);

  // synchronised reset
  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // two-stage synchronisers for event and halt
  logic [1:0] async_meta;
  logic [1:0] async_sync;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      async_meta <= 2'b00;
      async_sync <= 2'b00;
    end else begin
      async_meta <= {cpu_halted, event_b_in};
      async_sync <= async_meta;
    end
  end

  // register file
  logic [7:0] input_b_fault_mode;
  logic [7:0] fault_override_ctrl;
  logic [7:0] delay_ctrl;
  logic [7:0] delay_count;
  logic [7:0] fraction_ctrl;
  logic [7:0] fraction_value;
  logic [7:0] fraction_active;
  logic [7:0] debug_halt_ctrl;
  logic [7:0] event_b_ctrl;
  wire wr_mode = reg_write && reg_addr == `ADDR_INPUT_B_FAULT_MODE;
  wire wr_ovr = reg_write && reg_addr == `ADDR_FAULT_OVERRIDE_CTRL;
  wire wr_dctl = reg_write && reg_addr == `ADDR_DELAY_CTRL;
  wire wr_dcnt = reg_write && reg_addr == `ADDR_DELAY_COUNT;
  wire wr_fctl = reg_write && reg_addr == `ADDR_FRACTION_CTRL;
  wire wr_fval = reg_write && reg_addr == `ADDR_FRACTION_VALUE;
  wire wr_dbg = reg_write && reg_addr == `ADDR_DEBUG_HALT_CTRL;
  wire wr_evt = reg_write && reg_addr == `ADDR_EVENT_B_CTRL;
  wire wr_stat = reg_write && reg_addr == `ADDR_FAULT_STATUS;
  // protection unlock is the caller's job; this port accepts every write
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      input_b_fault_mode <= `REG_RESET;
      fault_override_ctrl <= `REG_RESET;
      delay_ctrl <= `REG_RESET;
      delay_count <= `REG_RESET;
      fraction_ctrl <= `REG_RESET;
      fraction_value <= `REG_RESET;
      debug_halt_ctrl <= `REG_RESET;
      event_b_ctrl <= `REG_RESET;
    end else begin
      if (wr_mode) input_b_fault_mode <= reg_wdata;
      if (wr_ovr) fault_override_ctrl <= reg_wdata;
      if (wr_dctl) delay_ctrl <= reg_wdata;
      if (wr_dcnt) delay_count <= reg_wdata;
      if (wr_fctl) fraction_ctrl <= reg_wdata;
      if (wr_fval) fraction_value <= reg_wdata;
      if (wr_dbg) debug_halt_ctrl <= reg_wdata;
      if (wr_evt) event_b_ctrl <= reg_wdata;
    end
  end

  // debug halt handling
  wire halted = async_sync[1];
  wire break_stop = halted && !debug_halt_ctrl[`BIT_DBG_RUN];
  assign timer_run = !break_stop;
  wire halt_fault = halted && debug_halt_ctrl[`BIT_HALT_FAULT];
  logic halt_fault_d;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) halt_fault_d <= 1'b0;
    else halt_fault_d <= halt_fault;
  end
  wire halt_fault_rise = halt_fault && !halt_fault_d;

  // event qualification: polarity, enable, blanking, break
  wire event_level = async_sync[0] ~^ event_b_ctrl[`BIT_EDGE_SEL];
  logic event_level_d;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) event_level_d <= 1'b0;
    else event_level_d <= event_level;
  end
  wire event_ok = event_b_ctrl[`BIT_TRIG_EN] && !input_blanking && !break_stop;
  wire trig_level = (event_ok && event_level) || halt_fault;
  wire trig_edge = (event_ok && event_level && !event_level_d) || halt_fault_rise;

  // mode decode
  reaction_e mode;
  always_comb begin
    unique case (input_b_fault_mode[`MODE_MSB:`MODE_LSB])
      4'h0: mode = mode_none;
      4'h1: mode = mode_jump_opposite_and_hold;
      4'h2: mode = mode_run_opposite_and_hold;
      4'h3: mode = mode_run_opposite_during_fault;
      4'h4: mode = mode_stop_all_keep_period;
      4'h5: mode = mode_deadband_during_fault;
      4'h6: mode = mode_stop_all_next_and_hold;
      4'h7: mode = mode_stop_all_until_software;
      4'h8: mode = mode_edge_stop_next_cycle;
      4'h9: mode = mode_edge_stop_keep_period;
      4'ha: mode = mode_level_stop_keep_period;
      default: mode = mode_none; // reserved codes act as none
    endcase
  end
  wire m_level = mode inside {mode_run_opposite_during_fault, mode_deadband_during_fault,
    mode_level_stop_keep_period};
  wire m_all = mode inside {mode_stop_all_keep_period, mode_deadband_during_fault,
    mode_stop_all_next_and_hold, mode_stop_all_until_software};
  wire m_sw = mode == mode_stop_all_until_software;
  wire m_hold = mode inside {mode_jump_opposite_and_hold, mode_run_opposite_and_hold,
    mode_stop_all_next_and_hold};
  wire m_cycle = mode inside {mode_stop_all_keep_period, mode_edge_stop_next_cycle,
    mode_edge_stop_keep_period};

  // fault latch: edge modes end at cycle end, hold modes wait for release
  logic fault_latched;
  wire sw_release = wr_stat && reg_wdata[`BIT_SW_RELEASE];
  wire latch_set = trig_edge && mode != mode_none && !m_level;
  wire latch_clr = (m_cycle && compare_b_fall_cycle_end && !trig_level) ||
    ((m_hold || m_sw) && sw_release && !trig_level) || mode == mode_none;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) fault_latched <= 1'b0;
    else if (latch_set) fault_latched <= 1'b1; // set wins over clear
    else if (latch_clr) fault_latched <= 1'b0;
  end
  wire fault_active = fault_latched || (m_level && trig_level);

  // sequencer requests
  assign jump_opposite = latch_set && mode == mode_jump_opposite_and_hold;
  assign hold_cycle = fault_latched && (m_hold || m_sw);
  assign run_deadband = fault_active && mode == mode_deadband_during_fault;
  assign jump_next = latch_set && (mode == mode_edge_stop_next_cycle ||
    mode == mode_stop_all_next_and_hold);
  assign trigger_a_flag_set = halt_fault_rise;
  assign trigger_b_flag_set = trig_edge;

  // stop mask: all outputs, or only the output of the running ramp
  logic ramp_b;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) ramp_b <= 1'b0;
    else if (compare_b_fall_cycle_end) ramp_b <= 1'b0;
    else if (compare_a_fall) ramp_b <= 1'b1;
  end
  // opposite-cycle modes stop only the affected output, others run on
  wire [OUTPUTS-1:0] affected = m_all ? {OUTPUTS{1'b1}} :
    (ramp_b ? OUTPUTS'(2) : OUTPUTS'(1));

  // per-output override and pin register
  wire [3:0] ovr_en = fault_override_ctrl[`OVR_EN_MSB:`OVR_EN_LSB];
  wire [3:0] ovr_lvl = fault_override_ctrl[`OVR_LVL_MSB:`OVR_LVL_LSB];
  logic [OUTPUTS-1:0] next_pin;
  always_comb begin
    for (int i = 0; i < OUTPUTS; i++) begin
      if (fault_active && affected[i]) begin
        next_pin[i] = ovr_en[i] ? ovr_lvl[i] : 1'b0;
      end else begin
        next_pin[i] = waveform_raw[i];
      end
    end
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) waveform_pin <= '0;
    else waveform_pin <= next_pin;
  end

  // delay start and prescaler
  wire [1:0] dly_sel = delay_ctrl[`DLY_SEL_MSB:`DLY_SEL_LSB];
  wire [1:0] dly_trig = delay_ctrl[`DLY_TRIG_MSB:`DLY_TRIG_LSB];
  wire [1:0] dly_div = delay_ctrl[`DLY_DIV_MSB:`DLY_DIV_LSB];
  wire [3:0] start_srcs = {compare_b_fall_cycle_end, compare_b_rise,
    compare_a_fall, compare_a_rise};
  wire dly_on = dly_sel == 2'h1 || dly_sel == 2'h2;
  wire dly_start = dly_on && timer_run && start_srcs[dly_trig];
  logic [2:0] presc;
  wire [2:0] presc_mask = 3'((4'h1 << dly_div) - 4'h1);
  wire presc_tick = (presc & presc_mask) == presc_mask;
  delay_state_e dly_state;
  logic [DELAY_BITS-1:0] dly_left;
  // a break freezes the count, so no repeated done pulse while halted
  wire dly_done = dly_state == dly_count && timer_run && presc_tick && dly_left == '0;
  // a restart reloads the count so a fresh trigger always gives full length
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dly_state <= dly_idle;
      dly_left <= '0;
      presc <= 3'h0;
    end else if (!dly_on) begin
      dly_state <= dly_idle;
    end else if (dly_start) begin
      dly_state <= dly_count;
      dly_left <= DELAY_BITS'(delay_count);
      presc <= 3'h0;
    end else if (dly_state == dly_count && timer_run) begin
      presc <= presc + 3'h1;
      if (presc_tick) begin
        if (dly_left == '0) dly_state <= dly_idle;
        else dly_left <= dly_left - 1'b1;
      end
    end
  end
  assign input_blanking = dly_state == dly_count && dly_sel == 2'h1;
  logic delayed_event_q;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) delayed_event_q <= 1'b0;
    else delayed_event_q <= dly_done && dly_sel == 2'h2;
  end
  assign delayed_event = delayed_event_q;

  // fractional accumulator with buffered value
  logic [3:0] frac_acc;
  logic step_q;
  wire [4:0] frac_sum = {1'b0, frac_acc} + {1'b0, fraction_active[`FRAC_MSB:`FRAC_LSB]};
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fraction_active <= `REG_RESET;
      frac_acc <= 4'h0;
      step_q <= 1'b0;
    end else begin
      if (update_strobe) fraction_active <= fraction_value;
      step_q <= 1'b0;
      if (compare_b_fall_cycle_end && timer_run) begin
        frac_acc <= frac_sum[3:0];
        step_q <= frac_sum[4];
      end
    end
  end
  assign fraction_step = step_q;
  assign fraction_ramp_select = fraction_ctrl[`RAMP_MSB:`RAMP_LSB];

  // read mux, data one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      `ADDR_INPUT_B_FAULT_MODE: rd_mux = input_b_fault_mode;
      `ADDR_FAULT_OVERRIDE_CTRL: rd_mux = fault_override_ctrl;
      `ADDR_DELAY_CTRL: rd_mux = {2'b00, delay_ctrl[5:0]};
      `ADDR_DELAY_COUNT: rd_mux = delay_count;
      `ADDR_FRACTION_CTRL: rd_mux = {6'h00, fraction_ctrl[1:0]};
      `ADDR_FRACTION_VALUE: rd_mux = {4'h0, fraction_value[3:0]};
      `ADDR_DEBUG_HALT_CTRL: rd_mux = {5'h00, debug_halt_ctrl[2], 1'b0, debug_halt_ctrl[0]};
      `ADDR_EVENT_B_CTRL: rd_mux = {3'h0, event_b_ctrl[4], 3'h0, event_b_ctrl[0]};
      `ADDR_FAULT_STATUS: rd_mux = {4'h0, frac_acc[1:0], fault_active, fault_latched};
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) reg_rdata <= 8'h00;
    else if (reg_read) reg_rdata <= rd_mux;
    else reg_rdata <= 8'h00;
  end

endmodule

// File: verification/pwm_fault_checker_assertions.sv
// concurrent checks on the fault, delay and fraction control block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/1ps
`include "pwm_fault_params.svh"
module pwm_fault_checker #(
  parameter int unsigned OUTPUTS = 4,
  parameter int unsigned DELAY_BITS = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  // timer core and debugger side
  input wire logic compare_b_fall_cycle_end,
  input wire logic cpu_halted,
  // block outputs
  input wire logic jump_opposite,
  input wire logic jump_next,
  input wire logic hold_cycle,
  input wire logic run_deadband,
  input wire logic timer_run,
  input wire logic trigger_a_flag_set,
  input wire logic trigger_b_flag_set,
  input wire logic delayed_event,
  input wire logic [1:0] fraction_ramp_select,
  input wire logic fraction_step,
  input wire logic [OUTPUTS-1:0] waveform_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [7:0] mode, ovr, dly, dbg;
  // shadow control bytes; own copy so a stuck register still shows
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= 8'h00;
      ovr <= 8'h00;
      dly <= 8'h00;
      dbg <= 8'h00;
    end else if (reg_write) begin
      if (reg_addr == `ADDR_INPUT_B_FAULT_MODE) mode <= reg_wdata;
      if (reg_addr == `ADDR_FAULT_OVERRIDE_CTRL) ovr <= reg_wdata;
      if (reg_addr == `ADDR_DELAY_CTRL) dly <= reg_wdata;
      if (reg_addr == `ADDR_DEBUG_HALT_CTRL) dbg <= reg_wdata;
    end
  end
  a_none_is_quiet: assert property (mode[3:0] == 4'h0 |->
    !jump_opposite && !jump_next && !hold_cycle && !run_deadband) else $error("mode 0 acted");
  a_jump_mode_one: assert property (jump_opposite |-> mode[3:0] == 4'h1)
    else $error("opposite jump outside mode 1");
  a_hold_modes: assert property (hold_cycle |-> mode[3:0] inside {4'h1, 4'h2, 4'h6, 4'h7})
    else $error("hold in wrong mode");
  a_next_modes: assert property (jump_next |-> mode[3:0] == 4'h6 || mode[3:0] == 4'h8)
    else $error("next jump in wrong mode");
  a_deadband_mode: assert property (run_deadband |-> mode[3:0] == 4'h5)
    else $error("dead-time in wrong mode");
  a_stop_all_zero: assert property (trigger_b_flag_set && mode[3:0] == 4'h4 && ovr == 8'h00
    |-> ##[1:4] waveform_pin[3:0] == 4'h0) else $error("outputs not stopped");
  a_override_pins: assert property (trigger_b_flag_set && mode[3:0] == 4'h7
    |-> ##[1:4] (waveform_pin[3:0] & ovr[7:4]) == (ovr[3:0] & ovr[7:4]))
    else $error("override level missing");
  a_ramp_follows: assert property ($past(reg_write) && $past(reg_addr) == `ADDR_FRACTION_CTRL
    |-> fraction_ramp_select == $past(reg_wdata[1:0])) else $error("ramp select stale");
  a_step_after_end: assert property (fraction_step |-> $past(compare_b_fall_cycle_end))
    else $error("step without cycle end");
  a_run_bit_set: assert property (dbg[0] |-> timer_run) else $error("timer stopped");
  a_halt_stops: assert property (cpu_halted [*4] ##0 !dbg[0] |-> !timer_run)
    else $error("timer ran in break");
  a_halt_flags: assert property (trigger_a_flag_set |-> trigger_b_flag_set && dbg[2])
    else $error("lone trigger a flag");
  a_event_sel_two: assert property (delayed_event |-> dly[1:0] == 2'h2)
    else $error("event outside event mode");
endmodule

// File: verification/fault_source.sv
// partner model: fault event source and debugger break source
// assumes the bench commands it right after rising clock edges
`timescale 1ns/1ps
module fault_source (
  // commands from the bench
  input wire logic fire,
  input wire logic rise_high,
  input wire logic halt_req,
  // lines into the block
  output logic event_b_in,
  output logic cpu_halted
);
  // active level follows edge select; the lag keeps it off clock edges
  initial begin
    event_b_in = 1'b0;
    cpu_halted = 1'b0;
  end
  always @(fire or rise_high) event_b_in <= #37 (fire ~^ rise_high);
  // break request, asynchronous to the timer clock
  always @(halt_req) cpu_halted <= #53 halt_req;
endmodule

// File: verification/pwm_fault_delay_fraction_ctrl_tb.sv
// self-checking bench for the fault, delay and fraction control block
// assumes the checker and fault source files compile before this one
`timescale 1ns/1ps
`include "pwm_fault_params.svh"
module pwm_fault_delay_fraction_ctrl_tb;
  localparam int unsigned OUTPUTS = 4;
  localparam int unsigned DELAY_BITS = 8;
  logic clock = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, update_strobe = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] ph = 4'h0, waveform_raw = 4'h0, waveform_pin, pexp;
  logic fire = 1'b0, rise_high = 1'b1, halt_req = 1'b0, event_b_in, cpu_halted, rd_d = 1'b0;
  logic jump_opposite, jump_next, hold_cycle, run_deadband, timer_run, pin_req = 1'b0;
  logic trigger_a_flag_set, trigger_b_flag_set, input_blanking, delayed_event, fraction_step;
  logic [1:0] fraction_ramp_select;
  logic [7:0] rd_q[$], pin_q[$];
  logic [7:0] amap[8] = '{8'h11, 8'h12, 8'h14, 8'h15, 8'h18, 8'h19, 8'h1e, 8'h30};
  logic [7:0] amsk[8] = '{8'h0f, 8'hff, 8'h3f, 8'hff, 8'h03, 8'h0f, 8'h05, 8'h00};
  logic [7:0] ovv[3] = '{8'hfa, 8'h3a, 8'hff};
  logic [7:0] evc[3] = '{8'h11, 8'h01, 8'h10};
  logic [7:0] dbv[3] = '{8'h04, 8'h01, 8'h00};
  logic [31:0] seed = 32'h5c3aec38;
  int n_fail = 0, samples_checked = 0, n_blank = 0, n_dev = 0, n_step = 0, n_trga = 0, b0, d;
  int n_jo = 0, n_jn = 0, b1;
  wire logic compare_a_rise = ph[0];
  wire logic compare_a_fall = ph[1];
  wire logic compare_b_rise = ph[2];
  wire logic compare_b_fall_cycle_end = ph[3];
  pwm_fault_delay_fraction_ctrl #(.OUTPUTS(OUTPUTS), .DELAY_BITS(DELAY_BITS)) DUT (
    .clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .compare_a_rise, .compare_a_fall, .compare_b_rise, .compare_b_fall_cycle_end,
    .update_strobe, .waveform_raw, .event_b_in, .cpu_halted, .jump_opposite, .jump_next,
    .hold_cycle, .run_deadband, .timer_run, .trigger_a_flag_set, .trigger_b_flag_set,
    .input_blanking, .delayed_event, .fraction_ramp_select, .fraction_step, .waveform_pin);
  fault_source src (.fire, .rise_high, .halt_req, .event_b_in, .cpu_halted);
  // 10 MHz timer clock
  initial begin
    forever #50 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bus cycles leave one idle cycle so no strobe is set twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic pins(input logic [3:0] exp);
    pin_q.push_back({4'h0, exp});
    pin_req <= 1'b1;
    @(posedge clock);
    pin_req <= 1'b0;
    @(posedge clock);
  endtask
  task automatic pulse(input int k);
    ph[k] <= 1'b1;
    @(posedge clock);
    ph <= 4'h0;
    @(posedge clock);
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // monitor: pops the oldest note when a result shows, counts pulses
  always @(posedge clock) begin
    rd_d <= reg_read;
    if (rd_d) check("rdata", reg_rdata, rd_q.pop_front());
    if (pin_req) check("pins", {4'h0, waveform_pin}, pin_q.pop_front());
    n_blank <= n_blank + int'(input_blanking === 1'b1);
    n_dev <= n_dev + int'(delayed_event === 1'b1);
    n_step <= n_step + int'(fraction_step === 1'b1);
    n_trga <= n_trga + int'(trigger_a_flag_set === 1'b1);
    n_jo <= n_jo + int'(jump_opposite === 1'b1);
    n_jn <= n_jn + int'(jump_next === 1'b1);
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    foreach (amap[i]) begin
      seed = lfsr(seed);
      rd(amap[i], 8'h00);
      wr(amap[i], (i == 7) ? seed[7:0] : seed[7:0] & amsk[i]);
      rd(amap[i], seed[7:0] & amsk[i]);
      wr(amap[i], 8'h00);
    end
    $display("register test done");
    wr(`ADDR_EVENT_B_CTRL, 8'h11);
    for (int m = 0; m < 12; m++) begin
      seed = lfsr(seed);
      waveform_raw <= seed[3:0];
      wr(`ADDR_INPUT_B_FAULT_MODE, 8'(m));
      b0 = n_jo;
      b1 = n_jn;
      fire <= 1'b1;
      repeat (8) @(posedge clock);
      pexp = (m == 0 || m == 11) ? seed[3:0] : (m >= 4 && m <= 7) ? 4'h0 : seed[3:0] & 4'he;
      pins(pexp);
      check("hold", {7'h0, hold_cycle}, {7'h0, m inside {1, 2, 6, 7}});
      check("deadband", {7'h0, run_deadband}, {7'h0, m == 5});
      check("opposite", 8'(n_jo - b0), 8'(m == 1));
      check("next", 8'(n_jn - b1), 8'(m == 6 || m == 8));
      rd(`ADDR_FAULT_STATUS, {6'h0, m % 11 != 0, !(m inside {0, 3, 5, 10, 11})});
      fire <= 1'b0;
      repeat (8) @(posedge clock);
      pulse(3);
      wr(`ADDR_FAULT_STATUS, 8'h01);
      repeat (4) @(posedge clock);
      pins(seed[3:0]);
    end
    $display("reaction mode test done");
    wr(`ADDR_INPUT_B_FAULT_MODE, 8'h07);
    for (int k = 0; k < 3; k++) begin
      wr(`ADDR_EVENT_B_CTRL, 8'h00);
      rise_high <= evc[k][4];
      repeat (4) @(posedge clock);
      wr(`ADDR_FAULT_OVERRIDE_CTRL, ovv[k]);
      wr(`ADDR_EVENT_B_CTRL, evc[k]);
      wr(`ADDR_FAULT_STATUS, 8'h01);
      fire <= 1'b1;
      repeat (8) @(posedge clock);
      pins(evc[k][0] ? ovv[k][7:4] & ovv[k][3:0] : waveform_raw);
      fire <= 1'b0;
      repeat (4) @(posedge clock);
      wr(`ADDR_FAULT_STATUS, 8'h01);
    end
    wr(`ADDR_EVENT_B_CTRL, 8'h00);
    wr(`ADDR_INPUT_B_FAULT_MODE, 8'h00);
    $display("override test done");
    // prescaler restarts with the delay start, yet the blanking width gets a window
    for (int s = 0; s < 4; s++) begin
      d = 1 << s;
      wr(`ADDR_DELAY_COUNT, 8'h03);
      wr(`ADDR_DELAY_CTRL, 8'(s << 4 | s << 2 | 1));
      b0 = n_blank;
      pulse((s + 1) % 4);
      repeat (40) @(posedge clock);
      pulse(s);
      repeat (80) @(negedge clock);
      check("blank", 8'(n_blank - b0 >= 3 * d + 1 && n_blank - b0 <= 4 * d + 1), 8'h01);
      @(posedge clock);
    end
    for (int s = 0; s < 3; s += 2) begin
      wr(`ADDR_DELAY_CTRL, 8'(12 | s));
      b0 = n_dev + n_blank;
      pulse(3);
      repeat (20) @(negedge clock);
      check("event", 8'(n_dev + n_blank - b0), 8'(s == 2 ? 1 : 0));
      @(posedge clock);
    end
    $display("delay test done");
    seed = lfsr(seed);
    wr(`ADDR_FRACTION_VALUE, {4'h0, seed[3:0] | 4'h1});
    for (int u = 0; u < 2; u++) begin
      b0 = n_step;
      repeat (16) pulse(3);
      @(negedge clock);
      check("steps", 8'(n_step - b0), u ? {4'h0, seed[3:0] | 4'h1} : 8'h00);
      @(posedge clock);
      update_strobe <= 1'b1;
      @(posedge clock);
      update_strobe <= 1'b0;
      @(posedge clock);
    end
    $display("fraction test done");
    foreach (dbv[j]) begin
      wr(`ADDR_DEBUG_HALT_CTRL, dbv[j]);
      b0 = n_trga;
      halt_req <= 1'b1;
      repeat (8) @(negedge clock);
      check("run", {7'h0, timer_run}, {7'h0, dbv[j][0]});
      check("flag a", 8'(n_trga - b0), {7'h0, dbv[j][2]});
      @(posedge clock);
      halt_req <= 1'b0;
      repeat (8) @(posedge clock);
      wr(`ADDR_FAULT_STATUS, 8'h01);
    end
    $display("debug test done");
    stop_test();
  end
endmodule
bind pwm_fault_delay_fraction_ctrl pwm_fault_checker #(.OUTPUTS(OUTPUTS), .DELAY_BITS(DELAY_BITS))
  chk (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .compare_b_fall_cycle_end,
  .cpu_halted, .jump_opposite, .jump_next, .hold_cycle, .run_deadband, .timer_run,
  .trigger_a_flag_set, .trigger_b_flag_set, .delayed_event, .fraction_ramp_select,
  .fraction_step, .waveform_pin);
